//--- hdl/tic_capture.sv
// Input capture unit: latches the 16-bit timer count on selected pin edges.
//
// Operation
// - Copy timer count into capture pair on event.
// - Mode picks falling, rising, fourth, sixteenth rising.
// - Every capture sets the capture interrupt flag.
// - Flag stays set until software clears it.
// - New capture overwrites unread value.
// - Pin level watched even when driven out.
// - Capture guaranteed only with synchronous timer.
// - Mode change may set flag spuriously.
// - Timer clocked from instruction or external clock.
// - Prescaler cleared when off, non-capture, reset.
`timescale 1ns/1ps
`include "tic_defines.svh"
module tic_capture
  import tic_pkg::*;
(
  mclk,
  sys_rst,
  capture_pin,
  timer16_count_high,
  timer16_count_low,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  capture_value_high,
  capture_value_low,
  capture_irq_flag,
  capture_irq
);
  input wire logic mclk;
  input wire logic sys_rst;
  input wire logic capture_pin;
  input wire logic [7:0] timer16_count_high;
  input wire logic [7:0] timer16_count_low;
  input wire logic [3:0] reg_addr;
  input wire logic [7:0] reg_wdata;
  input wire logic reg_wr;
  input wire logic reg_rd;
  output logic [7:0] reg_rdata;
  output logic [7:0] capture_value_high;
  output logic [7:0] capture_value_low;
  output logic capture_irq_flag;
  output logic capture_irq;

  // ****************************************
  // Mode decode
  // ****************************************
  function automatic logic is_capture_mode(input logic [3:0] m);
    is_capture_mode = (m[3:2] == 2'b01);
  endfunction

  logic [7:0] capture_control_reg;
  logic capture_irq_enable;
  logic [3:0] capture_mode_select;
  logic capture_on;
  tic_event_e event_kind;
  logic pin_level;
  logic rise_pulse;
  logic fall_pulse;
  logic [3:0] prescale_r;
  logic [3:0] prescale_nxt;
  logic capture_event;

  assign capture_mode_select = capture_control_reg[`TIC_MODE_MSB:`TIC_MODE_LSB];
  assign capture_on = is_capture_mode(capture_mode_select);
  assign event_kind = tic_event_e'(capture_mode_select[1:0]);

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // synchronise before detecting
  tic_pin_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(capture_pin),
    .pin_level(pin_level),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  // ****************************************
  // Event qualification
  // ****************************************
  // select qualifying event
  always_comb begin
    capture_event = 1'b0;
    prescale_nxt = prescale_r;
    if (capture_on) begin
      unique case (event_kind)
        TIC_EV_FALL: begin
          capture_event = fall_pulse;
        end
        TIC_EV_RISE: begin
          capture_event = rise_pulse;
        end
        TIC_EV_RISE4: begin
          if (rise_pulse) begin
            capture_event = (prescale_r[1:0] == 2'(`TIC_PS4_LAST));
            prescale_nxt = prescale_r + 4'h1;
          end
        end
        TIC_EV_RISE16: begin
          if (rise_pulse) begin
            capture_event = (prescale_r == `TIC_PS16_LAST);
            prescale_nxt = prescale_r + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !capture_on) begin
      prescale_r <= 4'h0;
    end else begin
      prescale_r <= prescale_nxt;
    end
  end

  // ****************************************
  // Capture register pair
  // ****************************************
  // latch timer count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      capture_value_high <= 8'h00;
      capture_value_low <= 8'h00;
    end else if (capture_event) begin
      capture_value_high <= timer16_count_high;
      capture_value_low <= timer16_count_low;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // mode write takes effect directly
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      capture_control_reg <= `TIC_CONTROL_RST;
      capture_irq_enable <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `TIC_ADDR_CONTROL) begin
        capture_control_reg <= reg_wdata;
      end
      if (reg_addr == `TIC_ADDR_ENABLE) begin
        capture_irq_enable <= reg_wdata[`TIC_FLAG_BIT];
      end
    end
  end

  // ****************************************
  // Interrupt flag
  // ****************************************
  // set flag on capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      capture_irq_flag <= 1'b0;
    end else if (capture_event) begin
      capture_irq_flag <= 1'b1;
    end else if (reg_wr && reg_addr == `TIC_ADDR_FLAG && reg_wdata[`TIC_FLAG_BIT]) begin
      capture_irq_flag <= 1'b0;
    end
  end

  // Interrupt registers the enabled flag or capture event, so it rises with the flag and drops one cycle after it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= capture_irq_enable && (capture_irq_flag || capture_event);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TIC_ADDR_CONTROL: reg_rdata <= capture_control_reg;
        `TIC_ADDR_VALUE_LOW: reg_rdata <= capture_value_low;
        `TIC_ADDR_VALUE_HIGH: reg_rdata <= capture_value_high;
        `TIC_ADDR_FLAG: reg_rdata <= {7'h00, capture_irq_flag};
        `TIC_ADDR_ENABLE: reg_rdata <= {7'h00, capture_irq_enable};
        `TIC_ADDR_STATUS: reg_rdata <= {3'h0, pin_level, prescale_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // tic_capture

//--- hdl/tic_defines.svh
// Register offsets, field positions, reset values and encodings of the input capture unit.
`ifndef TIC_DEFINES_SVH
`define TIC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define TIC_ADDR_CONTROL 4'h0
`define TIC_ADDR_VALUE_LOW 4'h1
`define TIC_ADDR_VALUE_HIGH 4'h2
`define TIC_ADDR_FLAG 4'h3
`define TIC_ADDR_ENABLE 4'h4
`define TIC_ADDR_STATUS 4'h5

// ****************************************
// Field layout and reset values
// ****************************************
`define TIC_MODE_LSB 0
`define TIC_MODE_MSB 3
`define TIC_FLAG_BIT 0
`define TIC_CONTROL_RST 8'h00
`define TIC_ENABLE_RST 8'h00

// ****************************************
// Mode encodings
// ****************************************
`define TIC_MODE_FALL 4'h4
`define TIC_MODE_RISE 4'h5
`define TIC_MODE_RISE4 4'h6
`define TIC_MODE_RISE16 4'h7

// ****************************************
// Prescale counts
// ****************************************
`define TIC_PS4_LAST 4'h3
`define TIC_PS16_LAST 4'hF

`endif

//--- hdl/tic_pin_sync.sv
// Three-stage pin synchroniser with edge detection.
`timescale 1ns/1ps
module tic_pin_sync (
  mclk,
  sys_rst,
  pin_in,
  pin_level,
  rise_pulse,
  fall_pulse
);
  input wire logic mclk;
  input wire logic sys_rst;
  input wire logic pin_in;
  output logic pin_level;
  output logic rise_pulse;
  output logic fall_pulse;

  logic meta_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      meta_r <= pin_in;
      s2_r <= meta_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        pin_level <= s3_r;
      end
    end
  end

  // A change counts once the second and third stages agree on it.
  assign rise_pulse = (s2_r == s3_r) && s3_r && !pin_level;
  assign fall_pulse = (s2_r == s3_r) && !s3_r && pin_level;
endmodule // tic_pin_sync

//--- hdl/tic_pkg.sv
// Types shared by the input capture unit.
package tic_pkg;
  typedef enum logic [1:0] {
    TIC_EV_FALL,
    TIC_EV_RISE,
    TIC_EV_RISE4,
    TIC_EV_RISE16
  } tic_event_e;
endpackage

//--- sim/testbench.sv
// Self-checking testbench of the input capture unit.
`timescale 1ns/1ps
`include "tic_defines.svh"
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic pin;
  logic [7:0] th = 8'h00;
  logic [7:0] tl = 8'h00;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, vh, vl;
  logic flag, irq;
  int n_fail = 0;
  int n_checks = 0;
  always #5 mclk = ~mclk;
  tic_pin_model pm_u (.mclk(mclk), .capture_pin(pin));
  tic_capture dut_u (.mclk(mclk), .sys_rst(sys_rst), .capture_pin(pin),
    .timer16_count_high(th), .timer16_count_low(tl), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .capture_value_high(vh),
    .capture_value_low(vl), .capture_irq_flag(flag), .capture_irq(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic t_modes;
    logic [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m = `TIC_MODE_FALL + i[3:0];
      wr_reg(`TIC_ADDR_CONTROL, 8'h00);
      wr_reg(`TIC_ADDR_CONTROL, {4'h0, m});
      wr_reg(`TIC_ADDR_FLAG, 8'h01);
      th <= {4'h1, m};
      tl <= {m, 4'hA};
      pm_u.pulses((i == 2) ? 3 : (i == 3) ? 15 : 0);
      chk({7'h00, flag}, 8'h00);
      pm_u.pulses(1);
      chk({7'h00, flag}, 8'h01);
      rd_chk(`TIC_ADDR_VALUE_HIGH, {4'h1, m});
      rd_chk(`TIC_ADDR_VALUE_LOW, {m, 4'hA});
    end
    $display("modes test done");
  endtask
  task automatic t_overwrite;
    wr_reg(`TIC_ADDR_CONTROL, {4'h0, `TIC_MODE_RISE});
    wr_reg(`TIC_ADDR_FLAG, 8'h01);
    th <= 8'h11;
    tl <= 8'h22;
    pm_u.pulses(1);
    @(posedge mclk);
    th <= 8'h33;
    tl <= 8'h44;
    pm_u.pulses(1);
    rd_chk(`TIC_ADDR_VALUE_LOW, 8'h44);
    rd_chk(`TIC_ADDR_VALUE_HIGH, 8'h33);
    rd_chk(`TIC_ADDR_FLAG, 8'h01);
    wr_reg(`TIC_ADDR_ENABLE, 8'h01);
    @(posedge mclk);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr_reg(`TIC_ADDR_ENABLE, 8'h00);
    @(posedge mclk);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr_reg(`TIC_ADDR_FLAG, 8'h01);
    rd_chk(`TIC_ADDR_FLAG, 8'h00);
    rd_chk(4'hF, 8'h00);
    $display("overwrite test done");
  endtask
  task automatic t_off;
    wr_reg(`TIC_ADDR_CONTROL, 8'h00);
    wr_reg(`TIC_ADDR_FLAG, 8'h01);
    pm_u.pulses(2);
    chk({7'h00, flag}, 8'h00);
    chk(vl, 8'h44);
    chk(vh, 8'h33);
    $display("off test done");
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({7'h00, flag}, 8'h00);
    t_modes;
    t_overwrite;
    t_off;
    close_out;
  end
  initial begin
    #100000;
    n_fail++;
    close_out;
  end
endmodule // testbench

//--- sim/tic_capture_chk.sv
// Port checker of the input capture unit.
`timescale 1ns/1ps
`include "tic_defines.svh"
module tic_capture_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic capture_pin,
  input wire logic [7:0] timer16_count_high,
  input wire logic [7:0] timer16_count_low,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] capture_value_high,
  input wire logic [7:0] capture_value_low,
  input wire logic capture_irq_flag,
  input wire logic capture_irq
);
  logic [3:0] mode_r;
  logic en_r;
  wire [15:0] val = {capture_value_high, capture_value_low};
  wire [15:0] tmr = {timer16_count_high, timer16_count_low};
  // Mirror of the mode and enable registers.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_r <= 4'h0;
      en_r <= 1'b0;
    end else if (reg_wr && reg_addr == `TIC_ADDR_CONTROL) begin
      mode_r <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == `TIC_ADDR_ENABLE) begin
      en_r <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_rise; mode_r == `TIC_MODE_RISE && $rose(capture_pin); endsequence
  sequence s_fall; mode_r == `TIC_MODE_FALL && $fell(capture_pin); endsequence
  property p_rise; s_rise |-> ##[2:6] capture_irq_flag; endproperty
  a_rise: assert property (p_rise) else $error("no capture on rise");
  property p_fall; s_fall |-> ##[2:6] capture_irq_flag; endproperty
  a_fall: assert property (p_fall) else $error("no capture on fall");
  property p_sticky;
    capture_irq_flag && !(reg_wr && reg_addr == `TIC_ADDR_FLAG && reg_wdata[0])
      |=> capture_irq_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_setflag; $changed(val) |-> capture_irq_flag; endproperty
  a_setflag: assert property (p_setflag) else $error("capture without flag");
  property p_copy; $changed(val) |-> val == $past(tmr); endproperty
  a_copy: assert property (p_copy) else $error("captured wrong count");
  property p_off; mode_r == 4'h0 [*3] |=> $stable(val); endproperty
  a_off: assert property (p_off) else $error("capture while off");
  property p_irqoff; !en_r [*2] |-> !capture_irq; endproperty
  a_irqoff: assert property (p_irqoff) else $error("masked irq high");
  property p_rdlow;
    reg_rd && reg_addr == `TIC_ADDR_VALUE_LOW |=> reg_rdata == $past(capture_value_low);
  endproperty
  a_rdlow: assert property (p_rdlow) else $error("bad low read");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
endmodule // tic_capture_chk
bind tic_capture tic_capture_chk chk_u (.mclk(mclk), .sys_rst(sys_rst),
  .capture_pin(capture_pin), .timer16_count_high(timer16_count_high),
  .timer16_count_low(timer16_count_low), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .capture_value_high(capture_value_high), .capture_value_low(capture_value_low),
  .capture_irq_flag(capture_irq_flag), .capture_irq(capture_irq));

//--- sim/tic_pin_model.sv
// Event source model that drives the capture pin.
`timescale 1ns/1ps
module tic_pin_model (
  input wire logic mclk,
  output logic capture_pin
);
  initial capture_pin = 1'b0;
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      capture_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      capture_pin <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    #1;
  endtask
endmodule // tic_pin_model
